// [logic/ahp_pkg.sv]
// Shared constants, pin layout and helpers for the asynchronous host bus port.
package ahp_pkg;

    localparam int DATA_W   = 32;
    localparam int REG_W    = 16;
    localparam int ADDR_W   = 4;
    localparam int NUM_REGS = 16;
    localparam int IRQ_W    = 3;

    // Multiplexed address sits on D5..D2, matching the A02..A05 byte-address weight.
    localparam int MUX_ADDR_LSB = 2;

    // Device pin sample vector layout.
    localparam int PIN_CS      = 0;
    localparam int PIN_OE      = 1;
    localparam int PIN_WE      = 2;
    localparam int PIN_ADDR    = 3;
    localparam int PIN_DATA    = PIN_ADDR + ADDR_W;
    localparam int PIN_MUX     = PIN_DATA + DATA_W;
    localparam int PIN_SIZE32  = PIN_MUX + 1;
    localparam int PIN_ORDER   = PIN_MUX + 2;
    localparam int PIN_W       = PIN_MUX + 3;
    localparam logic [PIN_W-1:0] PIN_RST = {{(PIN_W-3){1'b0}}, 3'h7};

    // Host sample vector: returned data followed by interrupt lines.
    localparam int HSMP_W = DATA_W + IRQ_W;

    // Cycles from reset release until the straps have crossed the synchroniser.
    // A strap driven from a register settles one cycle late, so one spare is kept.
    localparam logic [2:0] STRAP_CAP_CYC = 3'h6;

    // Address setup ahead of chip select, in picoseconds, and cycles at 100 MHz.
    localparam int CLK_PERIOD_PS    = 10000;
    localparam int ADDR_SETUP_PS    = 20;
    localparam int ADDR_SETUP_RAW   = (ADDR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [4:0] ADDR_SETUP_CYC = (ADDR_SETUP_RAW < 1) ? 5'h01 : 5'(ADDR_SETUP_RAW);

    // Host phase length; covers three-stage sampling on both ends with margin.
    localparam logic [4:0] PHASE_CYC = 5'h0c;
    localparam logic [4:0] BOOT_CYC  = 5'h10;

    // Puts a register value in bus order; big-endian swaps the two bytes.
    function automatic logic [REG_W-1:0] ahp_order(input logic [REG_W-1:0] v,
                                                   input logic little);
        ahp_order = little ? v : {v[7:0], v[15:8]};
    endfunction

endpackage

// [logic/ahp_bus_if.sv]
// Pin-level carrier joining the device end and the host end of the port.
interface ahp_bus_if;
    import ahp_pkg::*;

    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] register_addr_lines;
    logic [DATA_W-1:0] host_d_out;
    logic              host_d_oe_n;
    logic [DATA_W-1:0] dev_d_out;
    logic              dev_d_oe_n;
    logic [DATA_W-1:0] data;
    logic [IRQ_W-1:0]  irq_outputs;
    logic              mux_bus_strap;
    logic              size32_strap;
    logic              byte_order_strap;

    // Shared data lines resolve from the enables; an undriven bus reads low.
    assign data = !host_d_oe_n ? host_d_out : (!dev_d_oe_n ? dev_d_out : '0);

    modport dev (
        input  cs_n, oe_n, we_n, register_addr_lines, data,
        input  mux_bus_strap, size32_strap, byte_order_strap,
        output dev_d_out, dev_d_oe_n, irq_outputs
    );

    modport host (
        output cs_n, oe_n, we_n, register_addr_lines, host_d_out, host_d_oe_n,
        output mux_bus_strap, size32_strap, byte_order_strap,
        input  data, irq_outputs
    );
endinterface

// [logic/ahp_dev_end.sv]
// Device end of the asynchronous host bus port: pin sampling, straps and register file.
module ahp_dev_end
    import ahp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    ahp_bus_if.dev                 bus,
    input  wire logic [IRQ_W-1:0]  irq_req,
    input  wire logic              ld_en,
    input  wire logic [ADDR_W-1:0] ld_addr,
    input  wire logic [REG_W-1:0]  ld_data,
    output logic                   wr_pulse,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [REG_W-1:0]       wr_data,
    output logic                   mode_valid,
    output logic                   mux_mode,
    output logic                   bus_32,
    output logic                   little_end
);

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] flt_q;
    logic [PIN_W-1:0] flt_d;
    logic [PIN_W-1:0] prv_q;

    // Every bus pin and strap arrives unclocked, so all share one sampling chain.
    assign pin_raw = {bus.byte_order_strap, bus.size32_strap, bus.mux_bus_strap, bus.data,
                      bus.register_addr_lines, bus.we_n, bus.oe_n, bus.cs_n};

    // A change is accepted only when the second and third stages agree.
    for (genvar i = 0; i < PIN_W; i++) begin : g_flt
        always_comb begin
            flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
        end
    end

    // Sampling chain; the first stage feeds only the second.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= PIN_RST;
            s2_q  <= PIN_RST;
            s3_q  <= PIN_RST;
            flt_q <= PIN_RST;
            prv_q <= PIN_RST;
        end else begin
            s1_q  <= pin_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
            prv_q <= flt_q;
        end
    end

    logic              f_cs_n;
    logic              f_oe_n;
    logic              f_we_n;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] f_data;
    logic              cs_fall;
    logic              we_rise;

    // Filtered pin views and the edges the port reacts to.
    assign f_cs_n  = flt_q[PIN_CS];
    assign f_oe_n  = flt_q[PIN_OE];
    assign f_we_n  = flt_q[PIN_WE];
    assign f_addr  = flt_q[PIN_ADDR +: ADDR_W];
    assign f_data  = flt_q[PIN_DATA +: DATA_W];
    assign cs_fall = prv_q[PIN_CS] && !f_cs_n;
    assign we_rise = !prv_q[PIN_WE] && f_we_n;

    logic [2:0] cap_cnt_q;
    logic [2:0] cap_cnt_d;
    logic       done_q;
    logic       done_d;
    logic       mux_q;
    logic       mux_d;
    logic       b32_q;
    logic       b32_d;
    logic       lit_q;
    logic       lit_d;

    // Straps are held static around reset, so the value that has crossed the
    // sampling chain a few cycles after release is the value at the release.
    always_comb begin
        cap_cnt_d = cap_cnt_q;
        done_d    = done_q;
        mux_d     = mux_q;
        b32_d     = b32_q;
        lit_d     = lit_q;
        if (!done_q) begin
            cap_cnt_d = cap_cnt_q + 3'h1;
            if (cap_cnt_q == STRAP_CAP_CYC) begin
                mux_d  = flt_q[PIN_MUX];
                b32_d  = flt_q[PIN_SIZE32];
                lit_d  = flt_q[PIN_ORDER];
                done_d = 1'b1;
            end
        end
    end

    // Bus mode stays fixed until the next reset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_q <= 3'h0;
            done_q    <= 1'b0;
            mux_q     <= 1'b0;
            b32_q     <= 1'b0;
            lit_q     <= 1'b0;
        end else begin
            cap_cnt_q <= cap_cnt_d;
            done_q    <= done_d;
            mux_q     <= mux_d;
            b32_q     <= b32_d;
            lit_q     <= lit_d;
        end
    end

    logic [REG_W-1:0]  regs_q [NUM_REGS];
    logic [REG_W-1:0]  regs_d [NUM_REGS];
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic              wr_q;
    logic              wr_d;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [ADDR_W-1:0] wr_addr_d;
    logic [REG_W-1:0]  wr_data_q;
    logic [REG_W-1:0]  wr_data_d;
    logic [DATA_W-1:0] dout_q;
    logic [DATA_W-1:0] dout_d;
    logic              drive_q;
    logic              drive_d;
    logic [IRQ_W-1:0]  irq_q;

    // Address capture, register access and read data for the host.
    always_comb begin
        regs_d    = regs_q;
        addr_d    = addr_q;
        wr_d      = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        if (mux_q) begin
            // The A02 pin doubles as the strobe; address follows while it is high.
            if (f_addr[0]) begin
                addr_d = f_data[MUX_ADDR_LSB +: ADDR_W];
            end
        end else if (cs_fall) begin
            addr_d = f_addr;
        end
        // Local loads first, so a host write in the same cycle takes precedence.
        if (ld_en) begin
            regs_d[ld_addr] = ld_data;
        end
        // Writes take the low half only; D31..D16 are ignored in 32-bit mode.
        if (done_q && !f_cs_n && we_rise) begin
            wr_d              = 1'b1;
            wr_addr_d         = addr_q;
            wr_data_d         = ahp_order(f_data[REG_W-1:0], lit_q);
            regs_d[addr_q]    = wr_data_d;
        end
        drive_d = done_q && !f_cs_n && !f_oe_n && f_we_n;
        // D0 is bit 0 in both widths; the upper half is held low on reads.
        dout_d  = {{(DATA_W-REG_W){1'b0}}, ahp_order(regs_q[addr_q], lit_q)};
    end

    // Register file and port state.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                regs_q[r] <= '0;
            end
            addr_q    <= '0;
            wr_q      <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            dout_q    <= '0;
            drive_q   <= 1'b0;
            irq_q     <= '0;
        end else begin
            regs_q    <= regs_d;
            addr_q    <= addr_d;
            wr_q      <= wr_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            dout_q    <= dout_d;
            drive_q   <= drive_d;
            irq_q     <= irq_req;
        end
    end

    // Pin drivers; the data enable is low only while a read is in progress.
    assign bus.dev_d_out   = dout_q;
    assign bus.dev_d_oe_n  = !drive_q;
    assign bus.irq_outputs = irq_q;

    // User-side views of writes and of the strapped mode.
    assign wr_pulse   = wr_q;
    assign wr_addr    = wr_addr_q;
    assign wr_data    = wr_data_q;
    assign mode_valid = done_q;
    assign mux_mode   = mux_q;
    assign bus_32     = b32_q;
    assign little_end = lit_q;

endmodule

// [logic/ahp_host_end.sv]
// Host end of the asynchronous host bus port: a static memory controller sequencer.
module ahp_host_end
    import ahp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    ahp_bus_if.host                bus,
    input  wire logic              cfg_mux,
    input  wire logic              cfg_32,
    input  wire logic              cfg_little,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_write,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [REG_W-1:0]  cmd_wdata,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [REG_W-1:0]       rsp_rdata,
    output logic [IRQ_W-1:0]       irq_seen
);

    typedef enum logic [2:0] {H_BOOT, H_IDLE, H_ALE, H_SETUP, H_CS, H_STB, H_HOLD, H_GAP}
        ahp_hstate_e;

    logic [HSMP_W-1:0] smp_raw;
    logic [HSMP_W-1:0] h1_q;
    logic [HSMP_W-1:0] h2_q;
    logic [HSMP_W-1:0] h3_q;
    logic [HSMP_W-1:0] hf_q;
    logic [HSMP_W-1:0] hf_d;

    // Returned data and interrupt lines come from the other chip.
    assign smp_raw = {bus.irq_outputs, bus.data};

    for (genvar i = 0; i < HSMP_W; i++) begin : g_hflt
        always_comb begin
            hf_d[i] = (h2_q[i] == h3_q[i]) ? h3_q[i] : hf_q[i];
        end
    end

    // Three-stage sampling; the first stage feeds only the second.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            h1_q <= '0;
            h2_q <= '0;
            h3_q <= '0;
            hf_q <= '0;
        end else begin
            h1_q <= smp_raw;
            h2_q <= h1_q;
            h3_q <= h2_q;
            hf_q <= hf_d;
        end
    end

    ahp_hstate_e       st_q;
    ahp_hstate_e       st_d;
    logic [4:0]        cnt_q;
    logic [4:0]        cnt_d;
    logic              wr_q;
    logic              wr_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [REG_W-1:0]  wdat_q;
    logic [REG_W-1:0]  wdat_d;
    logic              mux_q;
    logic              lit_q;
    logic              b32_q;
    logic              rsp_q;
    logic              rsp_d;
    logic [REG_W-1:0]  rdat_q;
    logic [REG_W-1:0]  rdat_d;
    logic              cs_n_d;
    logic              oe_n_d;
    logic              we_n_d;
    logic [ADDR_W-1:0] al_d;
    logic [DATA_W-1:0] do_d;
    logic              doe_n_d;
    logic              cs_n_q;
    logic              oe_n_q;
    logic              we_n_q;
    logic [ADDR_W-1:0] al_q;
    logic [DATA_W-1:0] do_q;
    logic              doe_n_q;
    logic              phase_end;

    assign phase_end = (cnt_q == PHASE_CYC);

    // Access sequencer; each phase is long enough for the far end's sampling.
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q + 5'h01;
        wr_d    = wr_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rsp_d   = 1'b0;
        rdat_d  = rdat_q;
        cs_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        al_d    = '0;
        do_d    = '0;
        doe_n_d = 1'b1;
        case (st_q)
            H_BOOT: begin
                if (cnt_q == BOOT_CYC) begin
                    st_d  = H_IDLE;
                    cnt_d = '0;
                end
            end
            H_IDLE: begin
                cnt_d = '0;
                if (cmd_valid) begin
                    wr_d   = cmd_write;
                    addr_d = cmd_addr;
                    wdat_d = cmd_wdata;
                    st_d   = mux_q ? H_ALE : H_SETUP;
                end
            end
            H_ALE: begin
                // Strobe high with the address on the shared lines.
                al_d[0] = 1'b1;
                do_d[MUX_ADDR_LSB +: ADDR_W] = addr_q;
                doe_n_d = 1'b0;
                if (phase_end) begin
                    st_d  = H_SETUP;
                    cnt_d = '0;
                end
            end
            H_SETUP: begin
                al_d = mux_q ? '0 : addr_q;
                if (cnt_q == ADDR_SETUP_CYC) begin
                    st_d  = H_CS;
                    cnt_d = '0;
                end
            end
            H_CS, H_STB, H_HOLD: begin
                cs_n_d = 1'b0;
                al_d   = mux_q ? '0 : addr_q;
                if (wr_q) begin
                    do_d    = {{(DATA_W-REG_W){1'b0}}, ahp_order(wdat_q, lit_q)};
                    doe_n_d = 1'b0;
                end
                oe_n_d = !(st_q == H_STB && !wr_q);
                we_n_d = !(st_q == H_STB && wr_q);
                if (phase_end) begin
                    cnt_d = '0;
                    if (st_q == H_CS) begin
                        st_d = H_STB;
                    end else if (st_q == H_STB) begin
                        st_d   = H_HOLD;
                        rdat_d = ahp_order(hf_q[REG_W-1:0], lit_q);
                    end else begin
                        st_d  = H_GAP;
                        rsp_d = 1'b1;
                    end
                end
            end
            H_GAP: begin
                if (phase_end) begin
                    st_d  = H_IDLE;
                    cnt_d = '0;
                end
            end
            default: begin
                st_d  = H_BOOT;
                cnt_d = '0;
            end
        endcase
    end

    // Sequencer state and registered pin drive; straps follow the configuration.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= H_BOOT;
            cnt_q   <= '0;
            wr_q    <= 1'b0;
            addr_q  <= '0;
            wdat_q  <= '0;
            mux_q   <= 1'b0;
            lit_q   <= 1'b0;
            b32_q   <= 1'b0;
            rsp_q   <= 1'b0;
            rdat_q  <= '0;
            cs_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            al_q    <= '0;
            do_q    <= '0;
            doe_n_q <= 1'b1;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            mux_q   <= cfg_mux;
            lit_q   <= cfg_little;
            b32_q   <= cfg_32;
            rsp_q   <= rsp_d;
            rdat_q  <= rdat_d;
            cs_n_q  <= cs_n_d;
            oe_n_q  <= oe_n_d;
            we_n_q  <= we_n_d;
            al_q    <= al_d;
            do_q    <= do_d;
            doe_n_q <= doe_n_d;
        end
    end

    // Pin drive, command handshake outputs and the sampled interrupt lines.
    assign bus.cs_n                = cs_n_q;
    assign bus.oe_n                = oe_n_q;
    assign bus.we_n                = we_n_q;
    assign bus.register_addr_lines = al_q;
    assign bus.host_d_out          = do_q;
    assign bus.host_d_oe_n         = doe_n_q;
    assign bus.mux_bus_strap       = mux_q;
    assign bus.size32_strap        = b32_q;
    assign bus.byte_order_strap    = lit_q;
    assign cmd_ready               = (st_q == H_IDLE);
    assign rsp_valid               = rsp_q;
    assign rsp_rdata               = rdat_q;
    assign irq_seen                = hf_q[DATA_W +: IRQ_W];

endmodule

// [tb/ahp_bus_checker.sv]
// Concurrent checks on the pins that join the device end and the host end.
module ahp_bus_checker
    import ahp_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              cs_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic [ADDR_W-1:0] register_addr_lines,
    input wire logic              host_d_oe_n,
    input wire logic [DATA_W-1:0] dev_d_out,
    input wire logic              dev_d_oe_n,
    input wire logic              mux_bus_strap,
    input wire logic              size32_strap,
    input wire logic              byte_order_strap
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // A read strobe inside a frame must be answered before the host samples.
    sequence s_read_open;
        $fell(oe_n) && we_n && !cs_n;
    endsequence
    sequence s_dev_answer;
        ##[1:12] !dev_d_oe_n;
    endsequence
    // The address strobe phase opens the multiplexed cycle.
    sequence s_ale_open;
        $rose(register_addr_lines[0]) && mux_bus_strap;
    endsequence

    a_read_answer: assert property (s_read_open |-> s_dev_answer)
        else $error("device did not drive read data in time");
    a_read_release: assert property ($rose(oe_n) |-> ##[1:8] dev_d_oe_n)
        else $error("device kept driving after the read strobe");
    a_upper_low: assert property (!dev_d_oe_n && size32_strap |-> dev_d_out[31:16] == 16'h0)
        else $error("upper data lines not low on a wide read");
    a_no_clash: assert property (!host_d_oe_n |-> dev_d_oe_n)
        else $error("both ends drive the data lines");
    a_drive_in_frame: assert property (!dev_d_oe_n |-> !cs_n && we_n)
        else $error("device drives outside a read frame");
    a_addr_setup: assert property ($fell(cs_n) && !mux_bus_strap |-> $stable(register_addr_lines))
        else $error("address not set up ahead of chip select");
    a_mux_idle_lines: assert property (mux_bus_strap |-> register_addr_lines[3:1] == 3'h0)
        else $error("dedicated address lines used in multiplexed mode");
    a_ale_width: assert property (s_ale_open |-> (register_addr_lines[0] && !host_d_oe_n)[*8])
        else $error("address strobe phase too short");
    a_oe_width: assert property ($fell(oe_n) |-> !oe_n[*8])
        else $error("read strobe too short");
    a_straps_fixed: assert property (!cs_n |-> $stable({mux_bus_strap, size32_strap, byte_order_strap}))
        else $error("straps moved during an access");
endmodule

// [tb/test_async_host_bus_port.sv]
// Self-checking bench joining both ends of the host bus port through one carrier.
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_async_host_bus_port import ahp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              ref_clk, rst_n, ld_en, wr_pulse, mode_valid;
    logic              mux_mode, bus_32, little_end, cfg_mux, cfg_32, cfg_little;
    logic              cmd_valid, cmd_write, cmd_ready, rsp_valid;
    logic [IRQ_W-1:0]  irq_req, irq_seen;
    logic [ADDR_W-1:0] ld_addr, wr_addr, cmd_addr, wa;
    logic [REG_W-1:0]  ld_data, wr_data, cmd_wdata, rsp_rdata, wd;
    logic [DATA_W-1:0] rd_wire, wr_wire;
    int                n_mismatch = 0;
    int                num_checks = 0;
    int                n_cyc = 0;
    // Rows: write flag, address, write value, expected read value.
    logic [36:0]       rows [7] = '{{1'b1, 4'h0, 16'ha5c3, 16'h0}, {1'b0, 4'h0, 16'h0, 16'ha5c3},
        {1'b1, 4'hf, 16'h1234, 16'h0}, {1'b0, 4'hf, 16'h0, 16'h1234},
        {1'b0, 4'h7, 16'h0, 16'h7777}, {1'b1, 4'h9, 16'hffff, 16'h0},
        {1'b0, 4'h9, 16'h0, 16'hffff}};
    // Strap sets {mux, wide, little} so every strap is seen at both levels.
    logic [2:0]        modes [4] = '{3'h2, 3'h5, 3'h0, 3'h7};

    ahp_bus_if bus ();
    ahp_dev_end u_ahp_dev_end (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .irq_req(irq_req),
        .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data), .wr_pulse(wr_pulse),
        .wr_addr(wr_addr), .wr_data(wr_data), .mode_valid(mode_valid), .mux_mode(mux_mode),
        .bus_32(bus_32), .little_end(little_end));
    ahp_host_end u_ahp_host_end (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .cfg_mux(cfg_mux),
        .cfg_32(cfg_32), .cfg_little(cfg_little), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
    ahp_bus_checker u_ahp_bus_checker (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(bus.cs_n),
        .oe_n(bus.oe_n), .we_n(bus.we_n), .register_addr_lines(bus.register_addr_lines),
        .host_d_oe_n(bus.host_d_oe_n), .dev_d_out(bus.dev_d_out), .dev_d_oe_n(bus.dev_d_oe_n),
        .mux_bus_strap(bus.mux_bus_strap), .size32_strap(bus.size32_strap),
        .byte_order_strap(bus.byte_order_strap));

    // Expected bus order, worked out here so a shared slip cannot hide.
    function automatic logic [15:0] bo(input logic [15:0] v, input logic lit);
        return lit ? v : {v[7:0], v[15:8]};
    endfunction

    // Snoop the wire and the write port; the values are compared after each access.
    always @(posedge ref_clk) begin
        if (!bus.dev_d_oe_n) rd_wire <= bus.data;
        if (!bus.we_n) wr_wire <= bus.data;
        if (wr_pulse) {wa, wd} <= {wr_addr, wr_data};
        n_cyc <= n_cyc + 1;
        if (n_cyc == 12000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Straps are held steady through reset and checked once captured.
    task automatic do_reset(input logic [2:0] m);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        {cfg_mux, cfg_32, cfg_little} <= m;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK({bus.cs_n, bus.dev_d_oe_n, cmd_ready, mode_valid}, 4'hc)
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (24) @(negedge ref_clk);
        `CHK({mode_valid, mux_mode, bus_32, little_end}, {1'b1, m})
    endtask

    // One host access, held until taken, then compared at the wire and at the device end for writes or the host end for reads.
    task automatic op(input logic [36:0] r, input logic lit, input logic b32);
        int n;
        n = 0;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        {cmd_write, cmd_addr, cmd_wdata} <= r[36:16];
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(n < 200, 1'b1)
        if (r[36]) begin
            `CHK({wa, wd}, r[35:16])
            `CHK(wr_wire[15:0], bo(r[31:16], lit))
        end else begin
            `CHK(rsp_rdata, r[15:0])
            `CHK(rd_wire[15:0], bo(r[15:0], lit))
            if (b32) `CHK(rd_wire[31:16], 16'h0)
        end
    endtask

    initial begin
        {rst_n, ld_en, cfg_mux, cfg_32, cfg_little, cmd_valid, cmd_write} = 7'h0;
        {irq_req, ld_addr, cmd_addr, ld_data, cmd_wdata} = '0;
        for (int m = 0; m < 4; m++) begin
            do_reset(modes[m]);
            for (int i = 0; i < 16; i++) begin
                @(posedge ref_clk);
                ld_en <= 1'b1;
                ld_addr <= i[3:0];
                ld_data <= {4{i[3:0]}};
            end
            @(posedge ref_clk);
            ld_en <= 1'b0;
            foreach (rows[k]) op(rows[k], modes[m][0], modes[m][1]);
        end
        // Interrupt lines travel as 5 then 2, so each line is seen at both levels.
        for (int j = 0; j < 2; j++) begin
            @(posedge ref_clk);
            irq_req <= j[0] ? 3'h2 : 3'h5;
            repeat (10) @(negedge ref_clk);
            `CHK({bus.irq_outputs, irq_seen}, j[0] ? 6'h12 : 6'h2d)
        end
        // Reset in the middle of a read must free the bus at once.
        @(posedge ref_clk);
        {cmd_valid, cmd_write, cmd_addr} <= {2'h2, 4'h7};
        repeat (25) @(posedge ref_clk);
        cmd_valid <= 1'b0;
        rst_n <= 1'b0;
        @(negedge ref_clk);
        `CHK({bus.cs_n, bus.oe_n, bus.dev_d_oe_n, bus.host_d_oe_n}, 4'hf)
        do_reset(3'h2);
        op(rows[0], 1'b0, 1'b1);
        op(rows[1], 1'b0, 1'b1);
        end_of_test();
    end
endmodule
